// ===== verilog/ubm_top.sv
// Serial port with divisor baud generation, nine-bit multiprocessor address
// filtering and receive and transmit interrupt flags.
// Assumes a single-cycle register port and a receive line synchronous to clk_sys.
// Function
// - Mode 2 rate is system clock over 16.
// - Other modes: clock over 16 times prescale (1, 2, 4 or 8) times divisor+1.
// - Address filtering only in modes 2 and 3.
// - Modes 2,3 receive nine bits, store ninth.
// - Filter on: ninth bit zero raises nothing.
// - Filter enable ignored in mode 0.
// - Mode 1 filter: interrupt only valid stop.
// - Mode 0 receive flag at eighth bit midpoint.
// - Mode 1 receive flag at stop midpoint.
// - Modes 2,3 receive flag at ninth midpoint.
// - Receive request cleared on processor acknowledge.
// - Mode 0 transmit flag after eighth bit.
// - Modes 1-3 transmit flag at stop start.
// - One shared vector, separate event flags.
// - Modes 2,3 frame: start, 8 LSB-first, ninth, stop.
// - Ninth bit from control field or parity.
// - Enabled receiver starts on falling start edge.
`timescale 1ns/100ps
module ubm_top (
    input  wire logic       clk_sys,    // 25 MHz system clock
    input  wire logic       sys_rst,    // asynchronous reset, high
    input  wire logic [2:0] regAddr,    // register word address
    input  wire logic [7:0] regWdata,   // register write data
    input  wire logic       regWr,      // write strobe
    input  wire logic       regRd,      // read strobe
    output logic      [7:0] regRdata,   // read data, cycle after the strobe
    input  wire logic       rxLine,     // receive line
    output logic            txLine,     // transmit line
    input  wire logic       rxIrqAck,   // processor acknowledges receive request
    input  wire logic       txIrqAck,   // processor acknowledges transmit request
    output logic            rxIrqFlag,  // receive_irq_flag
    output logic            txIrqFlag,  // transmit_irq_flag
    output logic            irqReq      // shared serial interrupt request
);

    logic [7:0] ctrlHigh_reg;
    logic [7:0] ctrlLow_reg;
    logic [7:0] divisor_reg;
    logic [7:0] rxData_reg;
    logic [7:0] rdata_reg;
    logic       rxIrq_reg;
    logic       txIrq_reg;
    logic       rxEvt_reg;
    logic       txEvt_reg;
    logic       rb8_reg;

    ubm_pkg::ubm_state_e rxState_reg;
    ubm_pkg::ubm_state_e txState_reg;
    logic [3:0] rxPhase_reg;
    logic [3:0] txPhase_reg;
    logic [2:0] rxBit_reg;
    logic [2:0] txBit_reg;
    logic [7:0] rxShift_reg;
    logic [7:0] txShift_reg;
    logic       txNinth_reg;
    logic       txPend_reg;
    logic       rxPrev_reg;
    logic       txLine_reg;

    logic [1:0] mode;
    logic       multiproc_filter_enable;
    logic       rxEn;
    logic       tick16;
    logic       wrHigh;
    logic       wrLow;
    logic       wrDiv;
    logic       wrData;
    logic       wrFlags;
    logic       nineBit;
    logic       filterOn;
    logic       startEdge;
    logic       rxSample;
    logic       rxDone;
    logic       rxRaise;
    logic       txBitTick;
    logic       txRaise;
    logic       txLoad;
    logic [7:0] rxByte;
    logic [7:0] flagsView;
    logic [7:0] readMux;

    function automatic logic isNineBit(input logic [1:0] m);
        isNineBit = (m == ubm_pkg::MODE_2) || (m == ubm_pkg::MODE_3);
    endfunction

    assign mode     = ctrlHigh_reg[ubm_pkg::MODE_HI_POS:ubm_pkg::MODE_LO_POS];
    assign multiproc_filter_enable      = ctrlHigh_reg[ubm_pkg::MCE_POS];
    assign rxEn     = ctrlHigh_reg[ubm_pkg::RXEN_POS];
    assign nineBit  = isNineBit(mode);
    assign filterOn = multiproc_filter_enable && (mode != ubm_pkg::MODE_0);

    assign wrHigh  = regWr && (regAddr == ubm_pkg::ADDR_CTRL_HIGH);
    assign wrLow   = regWr && (regAddr == ubm_pkg::ADDR_CTRL_LOW);
    assign wrDiv   = regWr && (regAddr == ubm_pkg::ADDR_DIVISOR);
    assign wrData  = regWr && (regAddr == ubm_pkg::ADDR_DATA);
    assign wrFlags = regWr && (regAddr == ubm_pkg::ADDR_FLAGS);

    ubm_baud_gen ubm_baud_gen_inst (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .modeTwo (mode == ubm_pkg::MODE_2),
        .clkSel  (ctrlLow_reg[ubm_pkg::CLKSEL_HI_POS:ubm_pkg::CLKSEL_LO_POS]),
        .divisor (divisor_reg),
        .tick16  (tick16)
    );

    // Receive path.
    assign startEdge = rxEn && (rxState_reg == ubm_pkg::ST_IDLE)
                       && rxPrev_reg && !rxLine;
    assign rxSample  = tick16 && (rxPhase_reg == ubm_pkg::SAMPLE_PHASE);

    // The completion point of a frame depends on the mode; the flag rises there.
    assign rxDone = rxSample && (
        ((rxState_reg == ubm_pkg::ST_DATA) && (rxBit_reg == ubm_pkg::DATA_BIT_LAST)
            && (mode == ubm_pkg::MODE_0)) ||
        ((rxState_reg == ubm_pkg::ST_STOP) && (mode == ubm_pkg::MODE_1)) ||
        (rxState_reg == ubm_pkg::ST_NINTH));

    // In mode 1 the stop bit is checked only while filtering; in nine-bit
    // modes a zero ninth bit is dropped while filtering.
    assign rxRaise = rxDone && !(filterOn && !rxLine);

    // Mode 0 completes on the last data sample, before that bit reaches the
    // shifter, so the stored byte must take the bit straight from the line.
    assign rxByte = (rxState_reg == ubm_pkg::ST_DATA) ? {rxLine, rxShift_reg[7:1]}
                                                      : rxShift_reg;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rxState_reg <= ubm_pkg::ST_IDLE;
            rxPhase_reg <= 4'h0;
            rxBit_reg   <= 3'h0;
            rxShift_reg <= 8'h00;
            rxPrev_reg  <= 1'b1;
        end else begin
            rxPrev_reg <= rxLine;
            if (startEdge) begin
                rxPhase_reg <= 4'h0;
            end else if (tick16) begin
                rxPhase_reg <= rxPhase_reg + 4'h1;
            end
            case (rxState_reg)
                ubm_pkg::ST_IDLE: begin
                    if (startEdge) begin
                        rxState_reg <= ubm_pkg::ST_START;
                    end
                end
                ubm_pkg::ST_START: begin
                    if (rxSample) begin
                        rxBit_reg   <= 3'h0;
                        rxState_reg <= rxLine ? ubm_pkg::ST_IDLE : ubm_pkg::ST_DATA;
                    end
                end
                ubm_pkg::ST_DATA: begin
                    if (rxSample) begin
                        rxShift_reg <= {rxLine, rxShift_reg[7:1]};
                        rxBit_reg   <= rxBit_reg + 3'h1;
                        if (rxBit_reg == ubm_pkg::DATA_BIT_LAST) begin
                            rxState_reg <= nineBit ? ubm_pkg::ST_NINTH : ubm_pkg::ST_STOP;
                        end
                    end
                end
                ubm_pkg::ST_NINTH: begin
                    if (rxSample) begin
                        rxState_reg <= ubm_pkg::ST_STOP;
                    end
                end
                ubm_pkg::ST_STOP: begin
                    if (rxSample) begin
                        rxState_reg <= ubm_pkg::ST_IDLE;
                    end
                end
                default: begin
                    rxState_reg <= ubm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Transmit path; the bit clock free-runs so a frame starts on the next bit tick.
    assign txBitTick = tick16 && (txPhase_reg == ubm_pkg::OVERSAMPLE_LAST);
    assign txLoad    = wrData && (txState_reg == ubm_pkg::ST_IDLE) && !txPend_reg;
    assign txRaise   = txBitTick && (
        ((txState_reg == ubm_pkg::ST_DATA) && (txBit_reg == ubm_pkg::DATA_BIT_LAST)
            && !nineBit) ||
        (txState_reg == ubm_pkg::ST_NINTH));

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            txState_reg <= ubm_pkg::ST_IDLE;
            txPhase_reg <= 4'h0;
            txBit_reg   <= 3'h0;
            txShift_reg <= 8'h00;
            txNinth_reg <= 1'b0;
            txPend_reg  <= 1'b0;
            txLine_reg  <= 1'b1;
        end else begin
            if (tick16) begin
                txPhase_reg <= txPhase_reg + 4'h1;
            end
            if (txLoad) begin
                txShift_reg <= regWdata;
                txPend_reg  <= 1'b1;
                txNinth_reg <= ctrlLow_reg[ubm_pkg::PARITY_POS] ? ^regWdata
                                                               : ctrlHigh_reg[ubm_pkg::TB8_POS];
            end
            if (txBitTick) begin
                case (txState_reg)
                    ubm_pkg::ST_IDLE: begin
                        if (txPend_reg) begin
                            txPend_reg  <= 1'b0;
                            txLine_reg  <= 1'b0;
                            txBit_reg   <= 3'h0;
                            txState_reg <= ubm_pkg::ST_START;
                        end
                    end
                    ubm_pkg::ST_START: begin
                        txLine_reg  <= txShift_reg[0];
                        txShift_reg <= {1'b0, txShift_reg[7:1]};
                        txState_reg <= ubm_pkg::ST_DATA;
                    end
                    ubm_pkg::ST_DATA: begin
                        txBit_reg <= txBit_reg + 3'h1;
                        if (txBit_reg == ubm_pkg::DATA_BIT_LAST) begin
                            txLine_reg  <= nineBit ? txNinth_reg : 1'b1;
                            txState_reg <= nineBit ? ubm_pkg::ST_NINTH : ubm_pkg::ST_STOP;
                        end else begin
                            txLine_reg  <= txShift_reg[0];
                            txShift_reg <= {1'b0, txShift_reg[7:1]};
                        end
                    end
                    ubm_pkg::ST_NINTH: begin
                        txLine_reg  <= 1'b1;
                        txState_reg <= ubm_pkg::ST_STOP;
                    end
                    ubm_pkg::ST_STOP: begin
                        txState_reg <= ubm_pkg::ST_IDLE;
                    end
                    default: begin
                        txLine_reg  <= 1'b1;
                        txState_reg <= ubm_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Registers and flags. Hardware setting a flag wins over a clear in the same cycle.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlHigh_reg <= ubm_pkg::CTRL_HIGH_RST;
            ctrlLow_reg  <= ubm_pkg::CTRL_LOW_RST;
            divisor_reg  <= ubm_pkg::DIVISOR_RST;
            rxData_reg   <= ubm_pkg::DATA_RST;
            rb8_reg      <= 1'b0;
            rxIrq_reg    <= 1'b0;
            txIrq_reg    <= 1'b0;
            rxEvt_reg    <= 1'b0;
            txEvt_reg    <= 1'b0;
        end else begin
            if (wrHigh) begin
                ctrlHigh_reg <= regWdata;
            end
            if (wrLow) begin
                ctrlLow_reg <= regWdata;
            end
            if (wrDiv) begin
                divisor_reg <= regWdata;
            end
            if (rxDone && nineBit) begin
                rb8_reg <= rxLine;
            end
            if (rxRaise) begin
                rxData_reg <= rxByte;
            end
            if (rxRaise) begin
                rxIrq_reg <= 1'b1;
            end else if (rxIrqAck) begin
                rxIrq_reg <= 1'b0;
            end
            if (txRaise) begin
                txIrq_reg <= 1'b1;
            end else if (txIrqAck) begin
                txIrq_reg <= 1'b0;
            end
            // Event flags stay set until software writes a one over them.
            if (rxRaise) begin
                rxEvt_reg <= 1'b1;
            end else if (wrFlags && regWdata[ubm_pkg::RX_EVT_POS]) begin
                rxEvt_reg <= 1'b0;
            end
            if (txRaise) begin
                txEvt_reg <= 1'b1;
            end else if (wrFlags && regWdata[ubm_pkg::TX_EVT_POS]) begin
                txEvt_reg <= 1'b0;
            end
        end
    end

    assign flagsView = {4'h0, txIrq_reg, rxIrq_reg, txEvt_reg, rxEvt_reg};

    assign readMux =
        (regAddr == ubm_pkg::ADDR_CTRL_HIGH) ? {ctrlHigh_reg[7:3], rb8_reg, 2'h0} :
        (regAddr == ubm_pkg::ADDR_CTRL_LOW)  ? ctrlLow_reg :
        (regAddr == ubm_pkg::ADDR_DIVISOR)   ? divisor_reg :
        (regAddr == ubm_pkg::ADDR_DATA)      ? rxData_reg :
        (regAddr == ubm_pkg::ADDR_FLAGS)     ? flagsView : 8'h00;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= regRd ? readMux : 8'h00;
        end
    end

    assign regRdata  = rdata_reg;
    assign txLine    = txLine_reg;
    assign rxIrqFlag = rxIrq_reg;
    assign txIrqFlag = txIrq_reg;
    assign irqReq    = rxIrq_reg || txIrq_reg;

endmodule

// ===== include/ubm_pkg.sv
// Shared constants for the serial port block: register map, field positions,
// reset values, modes and the receiver and transmitter state encoding.
// Assumes an 8-bit register port with a 3-bit word address.
package ubm_pkg;

    localparam logic [2:0] ADDR_CTRL_HIGH = 3'h0;
    localparam logic [2:0] ADDR_CTRL_LOW  = 3'h1;
    localparam logic [2:0] ADDR_DIVISOR   = 3'h2;
    localparam logic [2:0] ADDR_DATA      = 3'h3;
    localparam logic [2:0] ADDR_FLAGS     = 3'h4;

    // Fields of serial_control_high.
    localparam int MODE_HI_POS     = 7;
    localparam int MODE_LO_POS     = 6;
    localparam int MCE_POS         = 5;
    localparam int RXEN_POS        = 4;
    localparam int TB8_POS         = 3;
    localparam int RB8_POS         = 2;
    // Fields of the low control register.
    localparam int PARITY_POS      = 7;
    localparam int CLKSEL_HI_POS   = 3;
    localparam int CLKSEL_LO_POS   = 2;
    // Fields of interrupt_flag_register.
    localparam int TX_IRQ_POS      = 3;
    localparam int RX_IRQ_POS      = 2;
    localparam int TX_EVT_POS      = 1;
    localparam int RX_EVT_POS      = 0;

    localparam logic [7:0] CTRL_HIGH_RST = 8'h00;
    localparam logic [7:0] CTRL_LOW_RST  = 8'h00;
    localparam logic [7:0] DIVISOR_RST   = 8'h00;
    localparam logic [7:0] DATA_RST      = 8'h00;

    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_1 = 2'h1;
    localparam logic [1:0] MODE_2 = 2'h2;
    localparam logic [1:0] MODE_3 = 2'h3;

    localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_PHASE    = 4'h7;
    localparam logic [2:0] DATA_BIT_LAST   = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_START = 3'h1,
        ST_DATA  = 3'h3,
        ST_NINTH = 3'h2,
        ST_STOP  = 3'h6
    } ubm_state_e;

endpackage

// ===== verilog/ubm_baud_gen.sv
// Baud generator: makes the 16x oversampling tick for the serial port.
// Assumes divisor and clock select are stable while a frame is on the line.
`timescale 1ns/100ps
module ubm_baud_gen (
    input  wire logic       clk_sys,   // system clock
    input  wire logic       sys_rst,   // asynchronous reset, high
    input  wire logic       modeTwo,   // fixed rate mode selected
    input  wire logic [1:0] clkSel,    // serial clock prescale select
    input  wire logic [7:0] divisor,   // baud_divisor_value
    output logic            tick16     // one pulse per sixteenth of a bit
);

    logic [2:0] preCnt_reg;
    logic [7:0] divCnt_reg;
    logic [2:0] preMask;
    logic       preTick;
    logic       divWrap;

    // Prescale ratios are 1, 2, 4 and 8 system clocks.
    assign preMask = 3'((4'h1 << clkSel) - 4'h1);
    assign preTick = (preCnt_reg & preMask) == preMask;
    assign divWrap = preTick && (divCnt_reg >= divisor);
    assign tick16  = modeTwo ? 1'b1 : divWrap;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            preCnt_reg <= 3'h0;
            divCnt_reg <= 8'h00;
        end else begin
            preCnt_reg <= preCnt_reg + 3'h1;
            if (divWrap) begin
                divCnt_reg <= 8'h00;
            end else if (preTick) begin
                divCnt_reg <= divCnt_reg + 8'h01;
            end
        end
    end

endmodule

// ===== test/ubm_checker.sv
// Checker for the serial port top: shared request, flag clearing and frame timing.
// Assumes mode and filter fields are only written while both lines are quiet.
`timescale 1ns/100ps
module ubm_checker (
    input wire logic       clk_sys,    // system clock
    input wire logic       sys_rst,    // asynchronous reset, high
    input wire logic [2:0] regAddr,    // register word address
    input wire logic [7:0] regWdata,   // register write data
    input wire logic       regWr,      // write strobe
    input wire logic       regRd,      // read strobe
    input wire logic [7:0] regRdata,   // read data
    input wire logic       rxLine,     // receive line
    input wire logic       txLine,     // transmit line
    input wire logic       rxIrqAck,   // receive acknowledge
    input wire logic       txIrqAck,   // transmit acknowledge
    input wire logic       rxIrqFlag,  // receive request
    input wire logic       txIrqFlag,  // transmit request
    input wire logic       irqReq      // shared request
);
    logic [7:0] ctrlReg;
    wire  [1:0] curMode = ctrlReg[ubm_pkg::MODE_HI_POS:ubm_pkg::MODE_LO_POS];
    wire        filtOn  = ctrlReg[ubm_pkg::MCE_POS];
    wire        rxOn    = ctrlReg[ubm_pkg::RXEN_POS];

    // A shadow of the control register lets the frame checks know the mode.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            ctrlReg <= 8'h00;
        else if (regWr && regAddr == ubm_pkg::ADDR_CTRL_HIGH)
            ctrlReg <= regWdata;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_irq_shared: assert property (irqReq == (rxIrqFlag | txIrqFlag))
        else $error("shared request differs from the flags");
    a_rx_ack_clear: assert property (rxIrqAck |=> !rxIrqFlag)
        else $error("receive request survived acknowledge");
    a_tx_ack_clear: assert property (txIrqAck |=> !txIrqFlag)
        else $error("transmit request survived acknowledge");
    a_tx_stop_high: assert property ($rose(txIrqFlag) |-> ##[0:1] txLine [*8])
        else $error("transmit flag not at stop bit");
    a_mode2_bit_len: assert property
        ($fell(txLine) && curMode == ubm_pkg::MODE_2 |-> (!txLine) [*8] ##1 (!txLine) [*8])
        else $error("low bit not sixteen clocks in fixed rate mode");
    a_filter_ninth: assert property
        ($rose(rxIrqFlag) && filtOn && curMode[1] |-> $past(rxLine))
        else $error("filtered frame with ninth bit low raised a request");
    a_mode1_stop: assert property
        ($rose(rxIrqFlag) && filtOn && curMode == ubm_pkg::MODE_1 |-> $past(rxLine))
        else $error("invalid stop bit raised a request");
    a_rx_disabled: assert property ($rose(rxIrqFlag) |-> rxOn)
        else $error("receive request while receiver disabled");
    a_rdata_idle: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data not zero outside read answer");

    c_rx_flag: cover property ($rose(rxIrqFlag));
    c_tx_flag: cover property ($rose(txIrqFlag));
    c_rx_ack: cover property (rxIrqAck && rxIrqFlag);
endmodule

bind ubm_top ubm_checker ubm_checker_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxLine(rxLine), .txLine(txLine),
    .rxIrqAck(rxIrqAck), .txIrqAck(txIrqAck), .rxIrqFlag(rxIrqFlag),
    .txIrqFlag(txIrqFlag), .irqReq(irqReq)
);

// ===== test/ubm_far_uart.sv
// Remote serial port on the far end of the lines: sends frames, decodes frames.
// Assumes it shares clk_sys and is told the bit length and frame size.
`timescale 1ns/100ps
module ubm_far_uart (
    input  wire logic        clk_sys,    // shared clock
    input  wire logic        txLine,     // frames from the block
    input  wire logic [15:0] bitClks,    // clocks per bit
    input  wire logic        nineBits,   // nine data bits per frame
    output logic             rxLine,     // frames to the block, idle high
    output logic             frameDone,  // pulse per decoded frame
    output logic       [9:0] frameWord   // stop, ninth, eight data bits
);
    logic [9:0] w;
    int         i;

    initial begin
        rxLine = 1'b1;
        frameDone = 1'b0;
        frameWord = 10'h000;
    end

    task automatic sendFrame(input logic [8:0] v, input logic nine, input logic stopB,
                             input int bc);
        int k;
        rxLine <= 1'b0;
        repeat (bc) @(posedge clk_sys);
        for (k = 0; k < 8 + nine; k++) begin
            rxLine <= v[k];
            repeat (bc) @(posedge clk_sys);
        end
        rxLine <= stopB;
        repeat (bc) @(posedge clk_sys);
        rxLine <= 1'b1;
        repeat (bc) @(posedge clk_sys);
    endtask

    // Samples mid-bit from the start edge, as a real receiver would.
    always begin
        @(negedge txLine);
        w = 10'h000;
        repeat (bitClks / 2) @(posedge clk_sys);
        for (i = 0; i < 8 + nineBits; i++) begin
            repeat (bitClks) @(posedge clk_sys);
            w[i] = txLine;
        end
        repeat (bitClks) @(posedge clk_sys);
        w[9] = txLine;
        frameWord <= w;
        frameDone <= 1'b1;
        @(posedge clk_sys);
        frameDone <= 1'b0;
    end
endmodule

// ===== test/ubm_top_test.sv
// Self-checking bench for the serial port top with a remote port model.
// Assumes the register map and flag clearing of the package constants.
`timescale 1ns/100ps
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t %s", $time, m); end end
module ubm_top_test;
    logic        clk_sys   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [2:0]  regAddr   = 3'h0;
    logic [7:0]  regWdata  = 8'h00;
    logic        regWr     = 1'b0;
    logic        regRd     = 1'b0;
    logic        rxIrqAck  = 1'b0;
    logic        txIrqAck  = 1'b0;
    logic [15:0] farBits   = 16'h0010;
    logic        farNine   = 1'b0;
    logic [7:0]  regRdata, d;
    logic        rxLine, txLine, rxIrqFlag, txIrqFlag, irqReq, farDone;
    logic [9:0]  farWord;
    logic [9:0]  expQ[$];
    int          fail_count = 0;
    int          checks_done = 0;
    int          i;

    always #20 clk_sys = ~clk_sys;

    ubm_top ubm_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .rxLine(rxLine), .txLine(txLine), .rxIrqAck(rxIrqAck), .txIrqAck(txIrqAck),
        .rxIrqFlag(rxIrqFlag), .txIrqFlag(txIrqFlag), .irqReq(irqReq));
    ubm_far_uart ubm_far_uart_inst (.clk_sys(clk_sys), .txLine(txLine), .bitClks(farBits),
        .nineBits(farNine), .rxLine(rxLine), .frameDone(farDone), .frameWord(farWord));

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic [7:0] rnd();
        return $urandom;
    endfunction

    task automatic regWrite(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic regRead(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask

    task automatic ack(input logic tx);
        @(posedge clk_sys);
        txIrqAck <= tx;
        rxIrqAck <= !tx;
        @(posedge clk_sys);
        txIrqAck <= 1'b0;
        rxIrqAck <= 1'b0;
        #1;
    endtask

    // Frames are compared when the far end has decoded them.
    always @(posedge farDone) begin
        `CHK(expQ.size() > 0, 1'b1, "unexpected transmit frame")
        if (expQ.size() > 0) `CHK(farWord, expQ.pop_front(), "transmit frame")
    end

    task automatic txCase(input logic [1:0] m, input logic [7:0] dv, input logic par);
        logic [7:0] v;
        logic       tb;
        int         n;
        v = rnd();
        tb = v[3] ^ v[6];
        regWrite(ubm_pkg::ADDR_CTRL_LOW, {par, 7'h00});
        regWrite(ubm_pkg::ADDR_DIVISOR, dv);
        regWrite(ubm_pkg::ADDR_CTRL_HIGH, {m, 2'h0, tb, 3'h0});
        farBits = (m == ubm_pkg::MODE_2) ? 16'h0010 : 16'(16'h0010 * (dv + 1));
        farNine = m[1];
        expQ.push_back({1'b1, m[1] & (par ? ^v : tb), v});
        regWrite(ubm_pkg::ADDR_DATA, v);
        for (n = 0; n < 4000 && txIrqFlag !== 1'b1; n++) @(posedge clk_sys);
        `CHK(txIrqFlag, 1'b1, "no transmit flag")
        `CHK(irqReq, 1'b1, "shared request missing")
        regRead(ubm_pkg::ADDR_FLAGS, d);
        `CHK(d[ubm_pkg::TX_EVT_POS], 1'b1, "transmit event flag")
        ack(1'b1);
        `CHK(txIrqFlag, 1'b0, "transmit request not cleared")
        `CHK(irqReq, 1'b0, "shared request stuck")
        regWrite(ubm_pkg::ADDR_FLAGS, 8'h02);
        regRead(ubm_pkg::ADDR_FLAGS, d);
        `CHK(d[ubm_pkg::TX_EVT_POS], 1'b0, "transmit event not cleared")
        repeat (farBits * 3) @(posedge clk_sys);
    endtask

    task automatic rxCase(input logic [1:0] m, input logic multiproc_filter_enable, input logic en,
                          input logic [8:0] w, input logic stopB, input logic expF);
        int k;
        k = (m == ubm_pkg::MODE_0) ? 8 : 9;
        regWrite(ubm_pkg::ADDR_CTRL_HIGH, {m, multiproc_filter_enable, en, 4'h0});
        fork
            ubm_far_uart_inst.sendFrame(w, m[1], stopB, 16);
            begin
                repeat (16 * k + 4) @(posedge clk_sys);
                `CHK(rxIrqFlag, 1'b0, "early receive flag")
                repeat (8) @(posedge clk_sys);
                `CHK(rxIrqFlag, expF, "receive flag")
            end
        join
        if (expF) begin
            regRead(ubm_pkg::ADDR_DATA, d);
            `CHK(d, w[7:0], "received byte")
            regRead(ubm_pkg::ADDR_CTRL_HIGH, d);
            if (m[1]) `CHK(d[ubm_pkg::RB8_POS], w[8], "received ninth bit")
            regRead(ubm_pkg::ADDR_FLAGS, d);
            `CHK(d[ubm_pkg::RX_EVT_POS], 1'b1, "receive event flag")
            ack(1'b0);
            `CHK(rxIrqFlag, 1'b0, "receive request not cleared")
            regWrite(ubm_pkg::ADDR_FLAGS, 8'h01);
            regRead(ubm_pkg::ADDR_FLAGS, d);
            `CHK(d[ubm_pkg::RX_EVT_POS], 1'b0, "receive event not cleared")
        end
    endtask

    initial begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        void'($urandom(32'h7ad6));
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        regWrite(3'h6, 8'h5a);
        for (i = 0; i < 8; i++) begin
            regRead(i[2:0], d);
            `CHK(d, 8'h00, "reset or unmapped value")
        end
        txCase(ubm_pkg::MODE_2, 8'h05, 1'b0);
        txCase(ubm_pkg::MODE_3, 8'h00, 1'b0);
        txCase(ubm_pkg::MODE_3, 8'h02, 1'b1);
        txCase(ubm_pkg::MODE_1, 8'h01, 1'b0);
        txCase(ubm_pkg::MODE_0, 8'h00, 1'b0);
        txCase(ubm_pkg::MODE_2, 8'h00, 1'b1);
        regWrite(ubm_pkg::ADDR_CTRL_LOW, 8'h00);
        regWrite(ubm_pkg::ADDR_DIVISOR, 8'h00);
        rxCase(ubm_pkg::MODE_2, 1'b1, 1'b1, {1'b1, rnd()}, 1'b1, 1'b1);
        rxCase(ubm_pkg::MODE_2, 1'b1, 1'b1, {1'b0, rnd()}, 1'b1, 1'b0);
        // The addressed slave drops its filter before the data bytes.
        rxCase(ubm_pkg::MODE_3, 1'b0, 1'b1, {1'b0, rnd()}, 1'b1, 1'b1);
        rxCase(ubm_pkg::MODE_1, 1'b1, 1'b1, {1'b0, rnd()}, 1'b0, 1'b0);
        rxCase(ubm_pkg::MODE_1, 1'b1, 1'b1, {1'b0, rnd()}, 1'b1, 1'b1);
        rxCase(ubm_pkg::MODE_0, 1'b1, 1'b1, {1'b0, rnd()}, 1'b0, 1'b1);
        rxCase(ubm_pkg::MODE_2, 1'b0, 1'b0, {1'b1, rnd()}, 1'b1, 1'b0);
        repeat (50) @(posedge clk_sys);
        `CHK(expQ.size(), 0, "frames never seen")
        end_sim();
    end
endmodule
